/* File: dv/rccb_capture_bench.sv */
// Self-checking bench for the receive control-cell capture buffer.
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module rccb_capture_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        cpu_wr, cpu_rd, cpu_rvalid_q, cell_byte_valid, cell_ready_q, cell_first, cell_last;
    logic        cell_icp, cell_good, diff_valid_q, diff_ready;
    logic [9:0]  cpu_addr;
    logic [15:0] cpu_wdata, cpu_rdata_q, diff_word_q, d;
    logic [3:0]  cell_link, diff_link_q;
    logic [7:0]  cell_byte;
    logic [19:0] e;
    int          failures = 0;
    int          total_checks = 0;
    always #50 clk = ~clk;
    rccb_capture #(.LINKS(16), .SLOTS(4)) uut (.clk(clk), .rst(rst), .ce(ce), .cpu_addr(cpu_addr),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata_q(cpu_rdata_q),
        .cpu_rvalid_q(cpu_rvalid_q), .cell_byte_valid(cell_byte_valid), .cell_ready_q(cell_ready_q),
        .cell_first(cell_first), .cell_last(cell_last), .cell_link(cell_link), .cell_byte(cell_byte),
        .cell_icp(cell_icp), .cell_good(cell_good), .diff_valid_q(diff_valid_q), .diff_ready(diff_ready),
        .diff_word_q(diff_word_q), .diff_link_q(diff_link_q));
    rccb_host u_host (.clk(clk), .cpu_rdata_q(cpu_rdata_q), .diff_valid_q(diff_valid_q),
        .diff_word_q(diff_word_q), .diff_link_q(diff_link_q), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .diff_ready(diff_ready));
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Byte k holds k, inverted at positions 3 and 53 (fl 1) or XORed with 55 everywhere (fl 2).
    task automatic send(input logic [3:0] l, input logic icp, input logic good, input int fl);
        for (int k = 1; k <= 53; k++) begin
            @(negedge clk);
            cell_byte_valid = 1'b1;
            cell_first = k == 1;
            cell_last = k == 53;
            cell_link = l;
            cell_icp = icp;
            cell_good = good;
            cell_byte = 8'(k) ^ (fl == 2 ? 8'h55 : fl == 1 && (k == 3 || k == 53) ? 8'hff : 8'h00);
            while (cell_ready_q !== 1'b1)
                @(negedge clk);
        end
        @(negedge clk);
        cell_byte_valid = 1'b0;
        cell_byte = ~cell_byte;
    endtask
    task automatic stat(input logic [3:0] l, input logic [1:0] w, input logic [1:0] r);
        u_host.stat(l, d);
        e = {10'h000, 2'(w - r), w, r};
        `CHK("status", e[15:0], d)
    endtask
    task automatic wait_for(input int n, input int lim);
        for (int i = 0; i < lim && u_host.got.size() < n; i++)
            @(negedge clk);
        `CHK("word count", n, u_host.got.size())
    endtask
    task automatic t_reset();
        logic [9:0] a[7] = '{10'h100, 10'h101, 10'h102, 10'h103, 10'h105, 10'h106, 10'h107};
        foreach (a[i]) begin
            u_host.rd(a[i], d);
            `CHK("reset value", 16'h0000, d)
        end
        $display("test reset done");
    endtask
    task automatic t_regs();
        logic [9:0]  a[3] = '{10'h100, 10'h101, 10'h102};
        logic [15:0] v[3] = '{16'h1b4e, 16'he4d8, 16'ha5c3};
        foreach (a[i]) begin
            u_host.wr(a[i], v[i]);
            u_host.rd(a[i], d);
            `CHK("readback", v[i], d)
        end
        u_host.wr(10'h103, 16'hffff);
        u_host.rd(10'h103, d);
        `CHK("unmapped", 16'h0000, d)
        @(negedge clk);
        ce = 1'b0;
        u_host.wr(10'h102, 16'h1234);
        ce = 1'b1;
        u_host.rd(10'h102, d);
        `CHK("frozen write", 16'ha5c3, d)
        $display("test regs done");
    endtask
    task automatic t_modes();
        logic [1:0] cnt[4] = '{2'h2, 2'h3, 2'h3, 2'h0};
        u_host.wr(10'h100, 16'h0390);
        u_host.wr(10'h102, 16'h0000);
        for (int i = 1; i <= 4; i++) begin
            send(4'(i), 1'b1, 1'b1, 0);
            send(4'(i), 1'b1, 1'b1, 0);
            send(4'(i), 1'b0, 1'b1, 0);
            send(4'(i), 1'b1, 1'b0, 1);
            send(4'(i), 1'b1, 1'b1, 1);
        end
        foreach (cnt[i])
            stat(4'(i + 1), cnt[i], 2'h0);
        u_host.rd(10'h107, d);
        `CHK("pending", 16'h0000, d)
        $display("test modes done");
    endtask
    task automatic t_adv();
        logic [1:0] w[5] = '{2'h0, 2'h2, 2'h3, 2'h3, 2'h0};
        logic [1:0] r[5] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h0};
        u_host.wr(10'h105, 16'h001f);
        foreach (w[i])
            stat(4'(i), w[i], r[i]);
        u_host.wr(10'h105, 16'h0004);
        stat(4'h2, 2'h3, 2'h2);
        stat(4'h3, 2'h3, 2'h1);
        $display("test advance done");
    endtask
    task automatic t_cmp();
        u_host.wr(10'h100, 16'h0400);
        u_host.wr(10'h102, 16'h0020);
        u_host.got.delete();
        u_host.stall = 1'b1;
        send(4'h5, 1'b1, 1'b1, 0);
        send(4'h5, 1'b1, 1'b1, 1);
        for (int i = 0; i < 300 && cell_ready_q !== 1'b1; i++)
            @(negedge clk);
        u_host.rd(10'h107, d);
        `CHK("pending", 16'h0020, d)
        u_host.stall = 1'b0;
        wait_for(2, 50);
        `CHK("first word", 20'h583fc, u_host.got[0])
        `CHK("last word", 20'h575ca, u_host.got[1])
        u_host.rd(10'h107, d);
        `CHK("pending", 16'h0000, d)
        $display("test compare done");
    endtask
    task automatic t_full();
        u_host.got.delete();
        u_host.stall = 1'b1;
        send(4'h5, 1'b1, 1'b1, 2);
        repeat (100)
            @(negedge clk);
        `CHK("input held", 1'b0, cell_ready_q)
        u_host.stall = 1'b0;
        wait_for(53, 400);
        for (int i = 0; i < 53; i++) begin
            e = {4'h5, 1'b0, i == 52, 6'(i + 1), 8'(i + 1) ^ 8'h55};
            `CHK("scan word", e, u_host.got[i] & 20'hf7fff)
        end
        d = {14'h0000, u_host.got[0][15], u_host.got[52][15]};
        `CHK("more flag", 16'h0002, d)
        stat(4'h5, 2'h3, 2'h0);
        send(4'h5, 1'b1, 1'b1, 0);
        stat(4'h5, 2'h3, 2'h0);
        $display("test full done");
    endtask
    initial begin
        #3000000;
        failures++;
        $display("ERROR watchdog expected finish seen timeout");
        test_done();
    end
    initial begin
        cell_byte_valid = 1'b0;
        cell_first = 1'b0;
        cell_last = 1'b0;
        cell_link = 4'h0;
        cell_byte = 8'h00;
        cell_icp = 1'b0;
        cell_good = 1'b0;
        repeat (8)
            @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_regs();
        t_modes();
        t_adv();
        t_cmp();
        t_full();
        test_done();
    end
endmodule

/* File: dv/rccb_capture_props.sv */
// Port checker for the capture buffer, bound to its top module.
module rccb_capture_chk (
    input logic        clk,
    input logic        rst,
    input logic        ce,
    input logic [9:0]  cpu_addr,
    input logic        cpu_rd,
    input logic [15:0] cpu_rdata_q,
    input logic        cpu_rvalid_q,
    input logic        diff_valid_q,
    input logic        diff_ready,
    input logic [15:0] diff_word_q,
    input logic [3:0]  diff_link_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic rd_st;
    logic rd_adv;
    assign rd_st = ce && cpu_rd && cpu_addr == 10'h106;
    assign rd_adv = ce && cpu_rd && cpu_addr == 10'h105;
    rd_answer_a: assert property (ce && cpu_rd |=> cpu_rvalid_q) else $error("read not answered");
    rvalid_pulse_a: assert property (!(ce && cpu_rd) |=> !cpu_rvalid_q) else $error("stray read valid");
    rdata_hold_a: assert property (!(ce && cpu_rd) |=> $stable(cpu_rdata_q)) else $error("read data moved");
    stat_zero_a: assert property (rd_st |=> cpu_rdata_q[15:6] == 10'h000) else $error("status top bits set");
    stat_level_a: assert property (rd_st |=> cpu_rdata_q[5:4] == cpu_rdata_q[3:2] - cpu_rdata_q[1:0])
        else $error("level not pointer difference");
    adv_zero_a: assert property (rd_adv |=> cpu_rdata_q == 16'h0000) else $error("advance read not zero");
    diff_hold_a: assert property (diff_valid_q && !diff_ready |=> diff_valid_q && $stable({diff_word_q, diff_link_q}))
        else $error("diff word dropped");
    diff_pos_a: assert property (diff_valid_q |-> diff_word_q[13:8] inside {[6'h01:6'h35]})
        else $error("diff position out of range");
    cover property (diff_valid_q && diff_ready && diff_word_q[14]);
    cover property (diff_valid_q && !diff_ready);
    cover property (rd_st);
endmodule

bind rccb_capture rccb_capture_chk u_chk (.clk(clk), .rst(rst), .ce(ce), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
    .cpu_rdata_q(cpu_rdata_q), .cpu_rvalid_q(cpu_rvalid_q), .diff_valid_q(diff_valid_q),
    .diff_ready(diff_ready), .diff_word_q(diff_word_q), .diff_link_q(diff_link_q));

/* File: dv/rccb_host.sv */
// Host model: register access tasks and the changed-byte word consumer.
module rccb_host (
    input  logic        clk,
    input  logic [15:0] cpu_rdata_q,
    input  logic        diff_valid_q,
    input  logic [15:0] diff_word_q,
    input  logic [3:0]  diff_link_q,
    output logic [9:0]  cpu_addr,
    output logic        cpu_wr,
    output logic        cpu_rd,
    output logic [15:0] cpu_wdata,
    output logic        diff_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        stall = 1'b0;
    logic [19:0] got[$];
    assign diff_ready = !stall;
    initial begin
        cpu_addr = 10'h000;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        cpu_wdata = 16'h0000;
    end
    always @(posedge clk) begin
        if (diff_valid_q && diff_ready)
            got.push_back({diff_link_q, diff_word_q});
    end
    // Write data is scrambled once released so a stale value is never mistaken for fresh.
    task automatic wr(input logic [9:0] a, input logic [15:0] v);
        @(negedge clk);
        cpu_addr = a;
        cpu_wdata = v;
        cpu_wr = 1'b1;
        @(negedge clk);
        cpu_wr = 1'b0;
        cpu_wdata = ~v;
    endtask
    task automatic rd(input logic [9:0] a, output logic [15:0] v);
        @(negedge clk);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge clk);
        cpu_rd = 1'b0;
        v = cpu_rdata_q;
    endtask
    // Select a link and read its status on the very next cycle.
    task automatic stat(input logic [3:0] l, output logic [15:0] v);
        @(negedge clk);
        cpu_addr = 10'h106;
        cpu_wdata = {12'h000, l};
        cpu_wr = 1'b1;
        @(negedge clk);
        cpu_wr = 1'b0;
        cpu_wdata = ~cpu_wdata;
        cpu_rd = 1'b1;
        @(negedge clk);
        cpu_rd = 1'b0;
        v = cpu_rdata_q;
    endtask
endmodule

/* File: hw/rccb_capture.v */
// Per-link receive capture buffer for control protocol cells with changed-byte detection.
//
// Overview of operation
// - Register 0x100 holds 2-bit capture selectors, link n in bits 2n+1:2n, links 0-7.
// - Register 0x101 holds capture selectors for links 8-15, link 8 lowest pair.
// - Selector 00 stores good control cells that differ from the previous stored, or any one when none is stored yet.
// - Selector 01 stores every good control cell of the link.
// - Selector 10 stores every good cell of the link, any type.
// - Selector 11 stores nothing for the link.
// - Compare-enable bit per link: new stored cell compared with previous stored cell.
// - Compare-enable bit at 0 means no changed-byte words for that link; selector 00 still compares bytes.
// - Writing 1 to bit n of 0x105 advances link n read pointer unless link n is empty; many at once.
// - Bits written 0 in 0x105 leave read pointers alone.
// - New status link selection shows on the very next read.
// - Status read gives level in 5:4, write pointer 3:2, read pointer 1:0.
// - Status bits 15:6 always read zero.
// - Each changed byte queues a word: more, last-in-cell, position 1-53, byte value.
// - Register 0x107 shows one bit per link: changed-byte words still unread.
`include "rccb_regs.vh"

module rccb_capture #(
    parameter LINKS = 16,
    parameter SLOTS = 4
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    input  wire [9:0]  cpu_addr,
    input  wire        cpu_wr,
    input  wire        cpu_rd,
    input  wire [15:0] cpu_wdata,
    output reg  [15:0] cpu_rdata_q,
    output reg         cpu_rvalid_q,
    input  wire        cell_byte_valid,
    output reg         cell_ready_q,
    input  wire        cell_first,
    input  wire        cell_last,
    input  wire [3:0]  cell_link,
    input  wire [7:0]  cell_byte,
    input  wire        cell_icp,
    input  wire        cell_good,
    output reg         diff_valid_q,
    input  wire        diff_ready,
    output reg  [15:0] diff_word_q,
    output reg  [3:0]  diff_link_q
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_SCAN  = 2'h1;
    localparam ST_FLUSH = 2'h2;

    reg  [7:0]  mem [0:4095];
    reg  [15:0] sel_lo_q;
    reg  [15:0] sel_hi_q;
    reg  [15:0] cmp_en_q;
    reg  [3:0]  stat_sel_q;
    reg  [31:0] wr_ptr_q;
    reg  [31:0] rd_ptr_q;
    reg  [15:0] has_prev_q;
    reg  [1:0]  st_q;
    reg  [1:0]  st_d;
    reg  [5:0]  idx_q;
    reg  [3:0]  rx_link_q;
    reg  [1:0]  rx_mode_q;
    reg         rx_icp_q;
    reg         rx_chg_q;
    reg  [3:0]  sc_link_q;
    reg  [1:0]  sc_new_q;
    reg  [1:0]  sc_old_q;
    reg  [5:0]  sc_idx_q;
    reg         pv_q;
    reg  [5:0]  pv_off_q;
    reg  [7:0]  pv_byte_q;
    reg  [79:0] pend_cnt_q;

    // Returns the 2-bit field of link n out of a packed per-link vector.
    function [1:0] field2;
        input [31:0] vec;
        input [3:0]  n;
        begin
            field2 = vec[{n, 1'b0} +: 2];
        end
    endfunction

    // Returns the capture selector of link n from the two selector registers.
    function [1:0] mode_of;
        input [15:0] lo;
        input [15:0] hi;
        input [3:0]  n;
        begin
            mode_of = field2({hi, lo}, n);
        end
    endfunction

    wire        wr_go    = ce & cpu_wr;
    wire        rx_take  = ce & cell_byte_valid & cell_ready_q;
    wire [3:0]  cur_link = cell_first ? cell_link : rx_link_q;
    wire [1:0]  cur_mode = cell_first ? mode_of(sel_lo_q, sel_hi_q, cell_link) : rx_mode_q;
    wire        cur_icp  = cell_first ? cell_icp : rx_icp_q;
    wire [1:0]  cur_wr   = field2(wr_ptr_q, cur_link);
    wire [1:0]  cur_lvl  = cur_wr - field2(rd_ptr_q, cur_link);
    wire [1:0]  cur_prv  = cur_wr - 2'h1;
    wire [5:0]  cur_idx  = cell_first ? 6'h00 : idx_q;
    wire        in_range = (cur_idx <= `RCCB_LAST_IDX);
    wire        byte_dif = (cell_byte != mem[{cur_link, cur_prv, cur_idx}]);
    wire        chg_now  = (cell_first ? 1'b0 : rx_chg_q) | (in_range & byte_dif);
    wire        cur_prev = has_prev_q[cur_link];

    // The buffer counts as full at level 3: with 2-bit pointers a fourth entry would alias empty.
    reg         accept;
    always @* begin
        case (cur_mode)
            `RCCB_MODE_ICP_CHG: accept = cur_icp & (chg_now | ~cur_prev);
            `RCCB_MODE_ICP_ALL: accept = cur_icp;
            `RCCB_MODE_ALL:     accept = 1'b1;
            default:            accept = 1'b0;
        endcase
    end
    wire        commit   = rx_take & cell_last & cell_good & accept & (cur_lvl != 2'h3);
    wire        start_sc = commit & cmp_en_q[cur_link] & cur_prev;

    // Scan of the newly stored slot against the previous one.
    wire        sc_dif   = (mem[{sc_link_q, sc_new_q, sc_idx_q}] != mem[{sc_link_q, sc_old_q, sc_idx_q}]);
    wire        f_ready;
    wire        stall    = sc_dif & pv_q & ~f_ready;
    wire        sc_step  = (st_q == ST_SCAN) & ~stall;
    wire        push_sc  = (st_q == ST_SCAN) & sc_dif & pv_q & f_ready;
    wire        push_fl  = (st_q == ST_FLUSH) & f_ready;
    wire        f_valid  = ce & (push_sc | push_fl);
    wire [18:0] f_in     = {sc_link_q, push_fl, pv_off_q, pv_byte_q};
    wire        f_out_v;
    wire [18:0] f_out;
    wire        load_out = ~diff_valid_q | diff_ready;
    wire        out_done = ce & diff_valid_q & diff_ready;
    wire [4:0]  pend_of  = pend_cnt_q[{1'b0, f_out[18:15], 2'b00} + {3'b000, f_out[18:15]} +: 5];
    // A word of the same link entering the queue now is still pending; the one leaving now is not.
    wire        pend_in  = f_valid & f_ready & (sc_link_q == f_out[18:15]);
    wire        pend_out = out_done & (diff_link_q == f_out[18:15]);
    wire [4:0]  pend_now = pend_of + {4'h0, pend_in} - {4'h0, pend_out};

    rccb_fifo #(
        .W     (19),
        .DEPTH (`RCCB_FIFO_DEPTH),
        .AW    (4)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (f_valid),
        .in_ready  (f_ready),
        .in_data   (f_in),
        .out_valid (f_out_v),
        .out_ready (load_out),
        .out_data  (f_out)
    );

    always @* begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (start_sc)
                    st_d = ST_SCAN;
            end
            ST_SCAN: begin
                if (sc_step && sc_idx_q == `RCCB_LAST_IDX)
                    st_d = (pv_q | sc_dif) ? ST_FLUSH : ST_IDLE;
            end
            ST_FLUSH: begin
                if (f_ready)
                    st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            st_q         <= ST_IDLE;
            cell_ready_q <= 1'b0;
            idx_q        <= 6'h00;
            rx_link_q    <= 4'h0;
            rx_mode_q    <= 2'h0;
            rx_icp_q     <= 1'b0;
            rx_chg_q     <= 1'b0;
            sc_link_q    <= 4'h0;
            sc_new_q     <= 2'h0;
            sc_old_q     <= 2'h0;
            sc_idx_q     <= 6'h00;
            pv_q         <= 1'b0;
            pv_off_q     <= 6'h00;
            pv_byte_q    <= 8'h00;
            has_prev_q   <= 16'h0000;
        end else if (ce) begin
            st_q         <= st_d;
            cell_ready_q <= (st_d == ST_IDLE);
            if (rx_take) begin
                rx_link_q <= cur_link;
                rx_mode_q <= cur_mode;
                rx_icp_q  <= cur_icp;
                rx_chg_q  <= chg_now;
                idx_q     <= (cur_idx == 6'h3f) ? cur_idx : cur_idx + 6'h01;
                if (in_range && cur_mode != `RCCB_MODE_NONE)
                    mem[{cur_link, cur_wr, cur_idx}] <= cell_byte;
            end
            if (commit)
                has_prev_q[cur_link] <= 1'b1;
            if (start_sc) begin
                sc_link_q <= cur_link;
                sc_new_q  <= cur_wr;
                sc_old_q  <= cur_prv;
                sc_idx_q  <= 6'h00;
                pv_q      <= 1'b0;
            end else if (sc_step) begin
                sc_idx_q <= sc_idx_q + 6'h01;
                if (sc_dif) begin
                    pv_q      <= 1'b1;
                    pv_off_q  <= sc_idx_q + 6'h01;
                    pv_byte_q <= mem[{sc_link_q, sc_new_q, sc_idx_q}];
                end
            end else if (push_fl) begin
                pv_q <= 1'b0;
            end
        end
    end

    // Output stage; the more-entries flag is judged when the word leaves the queue.
    always @(posedge clk) begin
        if (rst) begin
            diff_valid_q <= 1'b0;
            diff_word_q  <= 16'h0000;
            diff_link_q  <= 4'h0;
        end else if (ce && load_out) begin
            diff_valid_q <= f_out_v;
            if (f_out_v) begin
                diff_link_q <= f_out[18:15];
                diff_word_q <= {(pend_now > 5'h01), f_out[14:0]};
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < LINKS; g = g + 1) begin : g_link
            wire [1:0] lvl   = field2(wr_ptr_q, g) - field2(rd_ptr_q, g);
            wire       adv   = wr_go && cpu_addr == `RCCB_OFF_RD_ADV && cpu_wdata[g];
            wire       inc_p = f_valid & f_ready & (sc_link_q == g);
            wire       dec_p = out_done & (diff_link_q == g);
            always @(posedge clk) begin
                if (rst) begin
                    wr_ptr_q[2*g +: 2]   <= 2'h0;
                    rd_ptr_q[2*g +: 2]   <= 2'h0;
                    pend_cnt_q[5*g +: 5] <= 5'h00;
                end else if (ce) begin
                    if (commit && cur_link == g)
                        wr_ptr_q[2*g +: 2] <= wr_ptr_q[2*g +: 2] + 2'h1;
                    if (adv && lvl != 2'h0)
                        rd_ptr_q[2*g +: 2] <= rd_ptr_q[2*g +: 2] + 2'h1;
                    if (inc_p & ~dec_p)
                        pend_cnt_q[5*g +: 5] <= pend_cnt_q[5*g +: 5] + 5'h01;
                    else if (dec_p & ~inc_p)
                        pend_cnt_q[5*g +: 5] <= pend_cnt_q[5*g +: 5] - 5'h01;
                end
            end
        end
    endgenerate

    // Register writes.
    always @(posedge clk) begin
        if (rst) begin
            sel_lo_q   <= `RCCB_RST_SEL_LO;
            sel_hi_q   <= `RCCB_RST_SEL_HI;
            cmp_en_q   <= `RCCB_RST_CMP_EN;
            stat_sel_q <= `RCCB_RST_STAT_SEL;
        end else if (wr_go) begin
            case (cpu_addr)
                `RCCB_OFF_SEL_LO:   sel_lo_q   <= cpu_wdata;
                `RCCB_OFF_SEL_HI:   sel_hi_q   <= cpu_wdata;
                `RCCB_OFF_CMP_EN:   cmp_en_q   <= cpu_wdata;
                `RCCB_OFF_LVL_STAT: stat_sel_q <= cpu_wdata[`RCCB_STAT_SEL_HI:0];
                default: ;
            endcase
        end
    end

    // Register reads are answered one cycle after the read strobe.
    wire [1:0] st_wr = field2(wr_ptr_q, stat_sel_q);
    wire [1:0] st_rd = field2(rd_ptr_q, stat_sel_q);
    reg  [15:0] pend_bits;
    integer i;
    always @* begin
        pend_bits = 16'h0000;
        for (i = 0; i < LINKS; i = i + 1)
            pend_bits[i] = (pend_cnt_q[5*i +: 5] != 5'h00);
    end

    always @(posedge clk) begin
        if (rst) begin
            cpu_rdata_q  <= 16'h0000;
            cpu_rvalid_q <= 1'b0;
        end else if (ce) begin
            cpu_rvalid_q <= cpu_rd;
            if (cpu_rd) begin
                case (cpu_addr)
                    `RCCB_OFF_SEL_LO:    cpu_rdata_q <= sel_lo_q;
                    `RCCB_OFF_SEL_HI:    cpu_rdata_q <= sel_hi_q;
                    `RCCB_OFF_CMP_EN:    cpu_rdata_q <= cmp_en_q;
                    `RCCB_OFF_LVL_STAT:  cpu_rdata_q <= {10'h000, st_wr - st_rd, st_wr, st_rd};
                    `RCCB_OFF_PEND_STAT: cpu_rdata_q <= pend_bits;
                    default:             cpu_rdata_q <= 16'h0000;
                endcase
            end
        end
    end
endmodule

/* File: hw/rccb_fifo.v */
// Synchronous valid/ready FIFO used to queue changed-byte words.
module rccb_fifo #(
    parameter W     = 19,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire           clk,
    input  wire           rst,
    input  wire           ce,
    input  wire           in_valid,
    output wire           in_ready,
    input  wire [W-1:0]   in_data,
    output wire           out_valid,
    input  wire           out_ready,
    output wire [W-1:0]   out_data
);
    reg  [W-1:0]  mem [0:DEPTH-1];
    reg  [AW-1:0] wp_q;
    reg  [AW-1:0] rp_q;
    reg  [AW:0]   cnt_q;
    wire          push;
    wire          pop;

    assign in_ready  = (cnt_q != DEPTH);
    assign out_valid = (cnt_q != 0);
    assign out_data  = mem[rp_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk) begin
        if (rst) begin
            wp_q  <= {AW{1'b0}};
            rp_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (push) begin
                mem[wp_q] <= in_data;
                wp_q      <= (wp_q == DEPTH - 1) ? {AW{1'b0}} : wp_q + 1'b1;
            end
            if (pop)
                rp_q <= (rp_q == DEPTH - 1) ? {AW{1'b0}} : rp_q + 1'b1;
            if (push & ~pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop & ~push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

/* File: hw/rccb_regs.vh */
// Register map, field positions and constants of the receive control-cell capture buffer.
`ifndef RCCB_REGS_VH
`define RCCB_REGS_VH

`define RCCB_ADDR_W          10
`define RCCB_OFF_SEL_LO      10'h100
`define RCCB_OFF_SEL_HI      10'h101
`define RCCB_OFF_CMP_EN      10'h102
`define RCCB_OFF_RD_ADV      10'h105
`define RCCB_OFF_LVL_STAT    10'h106
`define RCCB_OFF_PEND_STAT   10'h107

`define RCCB_RST_SEL_LO      16'h0000
`define RCCB_RST_SEL_HI      16'h0000
`define RCCB_RST_CMP_EN      16'h0000
`define RCCB_RST_STAT_SEL    4'h0

`define RCCB_MODE_ICP_CHG    2'h0
`define RCCB_MODE_ICP_ALL    2'h1
`define RCCB_MODE_ALL        2'h2
`define RCCB_MODE_NONE       2'h3

`define RCCB_STAT_LVL_HI     5
`define RCCB_STAT_LVL_LO     4
`define RCCB_STAT_WR_HI      3
`define RCCB_STAT_WR_LO      2
`define RCCB_STAT_RD_HI      1
`define RCCB_STAT_RD_LO      0
`define RCCB_STAT_SEL_HI     3

`define RCCB_DIFF_MORE_BIT   15
`define RCCB_DIFF_LAST_BIT   14
`define RCCB_DIFF_OFF_HI     13
`define RCCB_DIFF_OFF_LO     8

`define RCCB_CELL_BYTES      53
`define RCCB_LAST_IDX        6'h34
`define RCCB_FIFO_DEPTH      16

`endif
